// >>> rtl/ust_pkg.sv
// Package of constants and types for the serial transmit block
package ust_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
	localparam logic [7:0] IDX_PERIPHERAL_FLAGS_1 = 8'h0C;
	localparam logic [7:0] IDX_RECEIVE_CONTROL = 8'h18;
	localparam logic [7:0] IDX_TRANSMIT_HOLDING = 8'h19;
	localparam logic [7:0] IDX_PERIPHERAL_ENABLES_1 = 8'h8C;
	localparam logic [7:0] IDX_TRANSMIT_CONTROL = 8'h98;
	localparam logic [7:0] IDX_BAUD_DIVISOR = 8'h99;
	localparam int ADDR_W = 12;
	// Reset values
	localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
	localparam logic [7:0] RST_PERIPHERAL_FLAGS_1 = 8'h00;
	localparam logic [7:0] RST_RECEIVE_CONTROL = 8'h00;
	localparam logic [7:0] RST_TRANSMIT_HOLDING = 8'h00;
	localparam logic [7:0] RST_PERIPHERAL_ENABLES_1 = 8'h00;
	localparam logic [7:0] RST_TRANSMIT_CONTROL = 8'h02;
	localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;
	// Field positions
	localparam int BIT_GLOBAL_IRQ_EN = 7;
	localparam int BIT_PERIPH_IRQ_EN = 6;
	localparam int BIT_TX_EMPTY_FLAG = 4;
	localparam int BIT_TX_EMPTY_IRQ_EN = 4;
	localparam int BIT_PORT_ENABLE = 7;
	localparam int BIT_SINGLE_RX_EN = 5;
	localparam int BIT_CONTINUOUS_RX_EN = 4;
	localparam int BIT_CLOCK_SOURCE_SEL = 7;
	localparam int BIT_NINE_BIT_TX = 6;
	localparam int BIT_TX_ENABLE = 5;
	localparam int BIT_SYNC_SEL = 4;
	localparam int BIT_UNUSED_TXC = 3;
	localparam int BIT_HIGH_SPEED_SEL = 2;
	localparam int BIT_SHIFTER_EMPTY = 1;
	localparam int BIT_TX_NINTH_BIT = 0;
	// Baud clock periods per bit: last count of the sub-bit counter
	localparam logic [5:0] SUB_LAST_HIGH_SPEED = 6'h0F;
	localparam logic [5:0] SUB_LAST_LOW_SPEED = 6'h3F;
	// Index of the last data bit for eight and nine bit frames
	localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
	localparam logic [3:0] LAST_BIT_NINE = 4'h8;
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_WAIT,
		PH_START,
		PH_DATA,
		PH_STOP
	} ust_phase_type;
	typedef struct packed {
		ust_phase_type phase;
		logic [8:0] shifter;
		logic [3:0] bit_cnt;
		logic [7:0] brg_cnt;
		logic [5:0] sub_cnt;
		logic ck_prev;
		logic [7:0] hold;
		logic hold_full;
		logic empty_flag;
		logic [7:0] interrupt_control;
		logic [7:0] pflags;
		logic [7:0] receive_control;
		logic [7:0] pie;
		logic [7:0] transmit_control;
		logic [7:0] divisor;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic tx_pin;
		logic tx_oe_n;
		logic dt_pin;
		logic dt_oe_n;
		logic irq;
		logic wake;
	} ust_state_type;
endpackage : ust_pkg

// >>> rtl/ust_transmitter.sv
// Serial port transmit path with APB register access
`timescale 1ns/10ps
`default_nettype none

module ust_transmitter (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic sleep_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ust_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic tx_pin_in,
	output logic tx_pin_out,
	output logic tx_pin_oe_n_out,
	output logic dt_pin_out,
	output logic dt_pin_oe_n_out,
	output logic irq_out,
	output logic wake_out
);
	import ust_pkg::*;

	ust_state_type cur;
	ust_state_type nxt;

	// Word-aligned address match against a register index
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		reg_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == {2'h0, idx});
	endfunction : reg_hit

	always_comb begin
		logic setup;
		logic wr_done;
		logic mapped;
		logic [7:0] rd_byte;
		logic async_run;
		logic slave_run;
		logic tx_active;
		logic bit_tick;
		logic ck_fall;
		logic hold_wr;
		logic en_rise;
		logic load;
		logic [3:0] last_bit;
		setup = 1'b0;
		wr_done = 1'b0;
		mapped = 1'b0;
		rd_byte = 8'h00;
		async_run = 1'b0;
		slave_run = 1'b0;
		tx_active = 1'b0;
		bit_tick = 1'b0;
		ck_fall = 1'b0;
		hold_wr = 1'b0;
		en_rise = 1'b0;
		load = 1'b0;
		last_bit = LAST_BIT_EIGHT;
		nxt = cur;

		// Bus decode
		setup = psel_in && !penable_in;
		wr_done = psel_in && penable_in && cur.pready && pwrite_in;
		mapped = reg_hit(paddr_in, IDX_INTERRUPT_CONTROL) ||
			reg_hit(paddr_in, IDX_PERIPHERAL_FLAGS_1) ||
			reg_hit(paddr_in, IDX_RECEIVE_CONTROL) ||
			reg_hit(paddr_in, IDX_TRANSMIT_HOLDING) ||
			reg_hit(paddr_in, IDX_PERIPHERAL_ENABLES_1) ||
			reg_hit(paddr_in, IDX_TRANSMIT_CONTROL) ||
			reg_hit(paddr_in, IDX_BAUD_DIVISOR);
		if (reg_hit(paddr_in, IDX_INTERRUPT_CONTROL)) begin
			rd_byte = cur.interrupt_control;
		end else if (reg_hit(paddr_in, IDX_PERIPHERAL_FLAGS_1)) begin
			rd_byte = cur.pflags;
			rd_byte[BIT_TX_EMPTY_FLAG] = cur.empty_flag;
		end else if (reg_hit(paddr_in, IDX_RECEIVE_CONTROL)) begin
			rd_byte = cur.receive_control;
		end else if (reg_hit(paddr_in, IDX_TRANSMIT_HOLDING)) begin
			rd_byte = cur.hold;
		end else if (reg_hit(paddr_in, IDX_PERIPHERAL_ENABLES_1)) begin
			rd_byte = cur.pie;
		end else if (reg_hit(paddr_in, IDX_TRANSMIT_CONTROL)) begin
			rd_byte = cur.transmit_control;
			rd_byte[BIT_UNUSED_TXC] = 1'b0;
			rd_byte[BIT_SHIFTER_EMPTY] = (cur.phase == PH_IDLE);
		end else if (reg_hit(paddr_in, IDX_BAUD_DIVISOR)) begin
			rd_byte = cur.divisor;
		end
		// Answer comes one cycle after setup; zero wait states
		nxt.pready = setup;
		if (setup) begin
			nxt.prdata = {24'h000000, rd_byte};
			nxt.pslverr = !mapped;
		end else begin
			nxt.pslverr = 1'b0;
		end

		if (wr_done && mapped) begin
			if (reg_hit(paddr_in, IDX_INTERRUPT_CONTROL)) begin
				nxt.interrupt_control = pwdata_in[7:0];
			end
			if (reg_hit(paddr_in, IDX_PERIPHERAL_FLAGS_1)) begin
				nxt.pflags = pwdata_in[7:0];
				nxt.pflags[BIT_TX_EMPTY_FLAG] = 1'b0;
			end
			if (reg_hit(paddr_in, IDX_RECEIVE_CONTROL)) begin
				nxt.receive_control = pwdata_in[7:0];
			end
			if (reg_hit(paddr_in, IDX_TRANSMIT_HOLDING)) begin
				hold_wr = 1'b1;
			end
			if (reg_hit(paddr_in, IDX_PERIPHERAL_ENABLES_1)) begin
				nxt.pie = pwdata_in[7:0];
			end
			if (reg_hit(paddr_in, IDX_TRANSMIT_CONTROL)) begin
				nxt.transmit_control = pwdata_in[7:0];
				nxt.transmit_control[BIT_UNUSED_TXC] = 1'b0;
				nxt.transmit_control[BIT_SHIFTER_EMPTY] = 1'b0;
				en_rise = pwdata_in[BIT_TX_ENABLE] && !cur.transmit_control[BIT_TX_ENABLE];
			end
			if (reg_hit(paddr_in, IDX_BAUD_DIVISOR)) begin
				nxt.divisor = pwdata_in[7:0];
			end
		end

		// Mode selection uses the settled register values
		tx_active = cur.receive_control[BIT_PORT_ENABLE] && cur.transmit_control[BIT_TX_ENABLE];
		// async when sync clear, frozen in sleep
		async_run = tx_active && !cur.transmit_control[BIT_SYNC_SEL] && !sleep_in;
		// slave runs from external clock even asleep
		slave_run = tx_active && cur.transmit_control[BIT_SYNC_SEL] && !cur.transmit_control[BIT_CLOCK_SOURCE_SEL];
		last_bit = cur.transmit_control[BIT_NINE_BIT_TX] ? LAST_BIT_NINE : LAST_BIT_EIGHT;

		// divisor counter and x16 or x64 sub-bit counter
		if (async_run) begin
			if (cur.brg_cnt == 8'h00) begin
				nxt.brg_cnt = cur.divisor;
				if (cur.sub_cnt == (cur.transmit_control[BIT_HIGH_SPEED_SEL] ?
					SUB_LAST_HIGH_SPEED : SUB_LAST_LOW_SPEED)) begin
					nxt.sub_cnt = 6'h00;
					bit_tick = 1'b1;
				end else begin
					nxt.sub_cnt = cur.sub_cnt + 6'h01;
				end
			end else begin
				nxt.brg_cnt = cur.brg_cnt - 8'h01;
			end
		end else if (!tx_active) begin
			nxt.brg_cnt = 8'h00;
			nxt.sub_cnt = 6'h00;
		end

		// slave shifts on falling clock edge
		nxt.ck_prev = tx_pin_in;
		ck_fall = cur.ck_prev && !tx_pin_in;

		if (!tx_active) begin
			nxt.phase = PH_IDLE;
			nxt.bit_cnt = 4'h0;
		end else begin
			case (cur.phase)
				PH_IDLE: begin
					// load at once when shifter empty
					// A same-cycle write defers the load one cycle so the empty flag is not set while the buffer is full
					if (cur.hold_full && !hold_wr && (async_run || slave_run)) begin
						load = 1'b1;
						nxt.shifter = {cur.transmit_control[BIT_TX_NINTH_BIT], cur.hold};
						nxt.bit_cnt = 4'h0;
						// slave starts at first data bit
						nxt.phase = slave_run ? PH_DATA : PH_WAIT;
					end
				end
				PH_WAIT: begin
					// start waits for a shift clock
					if (bit_tick) begin
						nxt.phase = PH_START;
					end
				end
				PH_START: begin
					if (bit_tick) begin
						nxt.phase = PH_DATA;
					end
				end
				PH_DATA: begin
					if ((async_run && bit_tick) || (slave_run && ck_fall)) begin
						nxt.shifter = {1'b0, cur.shifter[8:1]};
						nxt.bit_cnt = cur.bit_cnt + 4'h1;
						if (cur.bit_cnt == last_bit) begin
							nxt.phase = slave_run ? PH_IDLE : PH_STOP;
						end
					end
				end
				PH_STOP: begin
					// one stop bit, then free for reload
					if (bit_tick) begin
						nxt.phase = PH_IDLE;
					end
				end
				default: begin
					nxt.phase = PH_IDLE;
				end
			endcase
		end

		// move empties buffer in one cycle
		if (load) begin
			nxt.hold_full = 1'b0;
		end
		if (hold_wr) begin
			// ninth bit is taken from control at load time
			nxt.hold = pwdata_in[7:0];
			nxt.hold_full = 1'b1;
		end
		// cleared only by a holding write
		if (hold_wr) begin
			nxt.empty_flag = 1'b0;
		end
		// flag set on move or enable
		if (load || en_rise) begin
			nxt.empty_flag = 1'b1;
		end

		// wake ignores global enable; vector needs both enables
		nxt.wake = nxt.empty_flag && nxt.pie[BIT_TX_EMPTY_IRQ_EN];
		nxt.irq = nxt.wake && nxt.interrupt_control[BIT_GLOBAL_IRQ_EN] &&
			nxt.interrupt_control[BIT_PERIPH_IRQ_EN];

		// Pin drive from the next state keeps outputs flop-direct
		nxt.tx_pin = 1'b1;
		nxt.tx_oe_n = 1'b1;
		nxt.dt_pin = 1'b1;
		nxt.dt_oe_n = 1'b1;
		if (nxt.receive_control[BIT_PORT_ENABLE] && nxt.transmit_control[BIT_TX_ENABLE]) begin
			if (!nxt.transmit_control[BIT_SYNC_SEL]) begin
				nxt.tx_oe_n = 1'b0;
				nxt.tx_pin = (nxt.phase == PH_START) ? 1'b0 :
					(nxt.phase == PH_DATA) ? nxt.shifter[0] : 1'b1;
			end else if (!nxt.transmit_control[BIT_CLOCK_SOURCE_SEL]) begin
				// clock pin stays an input in slave mode
				nxt.dt_oe_n = 1'b0;
				nxt.dt_pin = (nxt.phase == PH_DATA) ? nxt.shifter[0] : 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			cur <= '0;
			cur.interrupt_control <= RST_INTERRUPT_CONTROL;
			cur.pflags <= RST_PERIPHERAL_FLAGS_1;
			cur.receive_control <= RST_RECEIVE_CONTROL;
			cur.hold <= RST_TRANSMIT_HOLDING;
			cur.pie <= RST_PERIPHERAL_ENABLES_1;
			cur.transmit_control <= RST_TRANSMIT_CONTROL & 8'hFD;
			cur.divisor <= RST_BAUD_DIVISOR;
			cur.tx_pin <= 1'b1;
			cur.tx_oe_n <= 1'b1;
			cur.dt_pin <= 1'b1;
			cur.dt_oe_n <= 1'b1;
			cur.ck_prev <= 1'b1;
		end else if (ce_in) begin
			cur <= nxt;
		end
	end

	assign prdata_out = cur.prdata;
	assign pready_out = cur.pready;
	assign pslverr_out = cur.pslverr;
	assign tx_pin_out = cur.tx_pin;
	assign tx_pin_oe_n_out = cur.tx_oe_n;
	assign dt_pin_out = cur.dt_pin;
	assign dt_pin_oe_n_out = cur.dt_oe_n;
	assign irq_out = cur.irq;
	assign wake_out = cur.wake;
endmodule : ust_transmitter

`default_nettype wire

// >>> verification/ust_checker.sv
// Assertion checker for the serial transmit block
`timescale 1ns/10ps
`default_nettype none
module ust_checker (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic sleep_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ust_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic tx_pin_in,
	input wire logic tx_pin_out,
	input wire logic tx_pin_oe_n_out,
	input wire logic dt_pin_out,
	input wire logic dt_pin_oe_n_out,
	input wire logic irq_out,
	input wire logic wake_out
);
	import ust_pkg::*;
	logic wr_done;
	logic ie_ff;
	assign wr_done = psel_in && penable_in && pready_out && pwrite_in;
	// Shadow of the empty interrupt enable, kept from completed writes
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			ie_ff <= 1'b0;
		end else if (wr_done && paddr_in == 12'h230) begin
			ie_ff <= pwdata_in[4];
		end
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	wake_irq_a: assert property (irq_out |-> wake_out)
		else $error("irq without wake");
	abort_release_a: assert property (wr_done && paddr_in == 12'h260 && !pwdata_in[5]
		|-> ##[1:2] tx_pin_oe_n_out) else $error("pin not released");
	start_len_a: assert property ($fell(tx_pin_out) && !tx_pin_oe_n_out
		|=> (!tx_pin_out || tx_pin_oe_n_out) [*8]) else $error("bit too short");
	sleep_hold_a: assert property (sleep_in && !psel_in |=> $stable(tx_pin_out))
		else $error("line moved in sleep");
	slave_edge_a: assert property ($rose(tx_pin_in) && !dt_pin_oe_n_out && !psel_in
		|=> $stable(dt_pin_out)) else $error("data moved on rising clock");
	flag_on_en_a: assert property (wr_done && paddr_in == 12'h260 && pwdata_in[5] && ie_ff
		|-> ##[1:2] wake_out) else $error("flag not set by enable");
	reset_idle_a: assert property ($fell(srst_in)
		|-> tx_pin_out && tx_pin_oe_n_out && dt_pin_oe_n_out && !irq_out)
		else $error("outputs not idle after reset");
	apb_answer_a: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
		else $error("bad bus answer");
endmodule : ust_checker
bind ust_transmitter ust_checker ust_checker_i (.*);
`default_nettype wire

// >>> verification/ust_far_end.sv
// Far-end model: async line receiver and sync clock master
`timescale 1ns/10ps
`default_nettype none
module ust_far_end (
	input wire logic clock_in,
	input wire logic line_in,
	input wire logic data_in,
	output logic ck_out
);
	initial ck_out = 1'b1;
	// start bit, data LSB first, stop bit
	task automatic rx_frame(input int n, p, output logic [8:0] d, output bit ok);
		int t;
		t = 0;
		d = 9'h1FF;
		while (line_in !== 1'b0 && t < 5000) begin
			@(posedge clock_in);
			t++;
		end
		repeat (p / 2) @(posedge clock_in);
		ok = (line_in === 1'b0);
		for (int i = 0; i < n; i++) begin
			repeat (p) @(posedge clock_in);
			d[i] = line_in;
		end
		repeat (p) @(posedge clock_in);
		ok = ok && (line_in === 1'b1) && t < 5000;
	endtask : rx_frame
	// clock from here; bit read while high, before the falling edge
	task automatic shift_in(input int n, output logic [8:0] d);
		d = 9'h1FF;
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clock_in);
			d[i] = data_in;
			ck_out <= 1'b0;
			repeat (4) @(posedge clock_in);
			ck_out <= 1'b1;
		end
	endtask : shift_in
endmodule : ust_far_end
`default_nettype wire

// >>> verification/testbench.sv
// Testbench for the serial transmit block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ust_pkg::*;
	logic clock_in = 1'b0;
	logic srst_in = 1'b1;
	logic sleep_in = 1'b0;
	logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
	logic pready_out, pslverr_out, tx_pin_out, tx_pin_oe_n_out, dt_pin_out, dt_pin_oe_n_out;
	logic irq_out, wake_out, ck, tx_line, er, hold;
	logic [8:0] got;
	bit ok;
	int err_total = 0, n_checks = 0;
	logic [11:0] adr [7] = '{12'h02C, 12'h030, 12'h060, 12'h064, 12'h230, 12'h260, 12'h264};
	// Pin is pulled up, so a released line shows the clock master's level
	assign tx_line = !tx_pin_oe_n_out ? tx_pin_out : ck;
	always #10 clock_in = ~clock_in;
	ust_transmitter ust_transmitter_i (.clock_in(clock_in), .srst_in(srst_in), .ce_in(1'b1),
		.sleep_in(sleep_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .tx_pin_in(tx_line),
		.tx_pin_out(tx_pin_out), .tx_pin_oe_n_out(tx_pin_oe_n_out), .dt_pin_out(dt_pin_out),
		.dt_pin_oe_n_out(dt_pin_oe_n_out), .irq_out(irq_out), .wake_out(wake_out));
	ust_far_end ust_far_end_i (.clock_in(clock_in), .line_in(tx_line), .data_in(dt_pin_out),
		.ck_out(ck));
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clock_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	task automatic cmp(input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : cmp
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(rd, e);
	endtask : rdc
	task automatic xfer(input int n, p, input logic [7:0] d, input logic [8:0] e);
		fork
			ust_far_end_i.rx_frame(n, p, got, ok);
			apb(1'b1, 12'h064, {24'h0, d});
		join
		cmp({ok, got}, {1'b1, e});
	endtask : xfer
	task automatic finish_test;
		if (err_total == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (40000) @(posedge clock_in);
		err_total++;
		finish_test();
	end
	initial begin
		repeat (2) @(posedge clock_in);
		srst_in <= 1'b0;
		for (int i = 0; i < 7; i++) rdc(adr[i], (i == 5) ? 32'h2 : 32'h0);
		rdc(12'h100, 32'h0);
		cmp(er, 1'b1);
		apb(1'b1, 12'h060, 32'h80);
		apb(1'b1, 12'h260, 32'h24);
		rdc(12'h030, 32'h10);
		fork
			begin
				ust_far_end_i.rx_frame(8, 16, got, ok);
				cmp({ok, got}, 10'h3A5);
				ust_far_end_i.rx_frame(8, 16, got, ok);
				cmp({ok, got}, 10'h33C);
			end
			begin
				apb(1'b1, 12'h064, 32'hA5);
				apb(1'b1, 12'h064, 32'h3C);
				rdc(12'h030, 32'h0);
				rdc(12'h260, 32'h24);
			end
		join
		repeat (20) @(posedge clock_in);
		rdc(12'h260, 32'h26);
		// Ninth bit set before the data write
		apb(1'b1, 12'h260, 32'h65);
		xfer(9, 16, 8'h5A, 9'h15A);
		apb(1'b1, 12'h264, 32'h1);
		apb(1'b1, 12'h260, 32'h20);
		xfer(8, 128, 8'hC3, 9'h1C3);
		apb(1'b1, 12'h064, 32'h96);
		repeat (30) @(posedge clock_in);
		sleep_in <= 1'b1;
		@(posedge clock_in);
		hold = tx_pin_out;
		repeat (2000) @(posedge clock_in);
		cmp(tx_pin_out, hold);
		sleep_in <= 1'b0;
		rdc(12'h260, 32'h20);
		apb(1'b1, 12'h264, 32'h0);
		apb(1'b1, 12'h260, 32'h24);
		apb(1'b1, 12'h064, 32'hFF);
		// Abort only once the word is in the shifter, so no stale word is left buffered
		rd = 32'h0;
		for (int i = 0; i < 200 && rd !== 32'h10; i++) apb(1'b0, 12'h030, 32'h0);
		cmp(rd, 32'h10);
		apb(1'b1, 12'h260, 32'h04);
		repeat (2) @(posedge clock_in);
		cmp(tx_pin_oe_n_out, 1'b1);
		rdc(12'h260, 32'h06);
		// Slave setup order: empty interrupt enable, global interrupts, sync transmit enable, then data
		apb(1'b1, 12'h230, 32'h10);
		apb(1'b1, 12'h02C, 32'hC0);
		apb(1'b1, 12'h260, 32'h30);
		repeat (2) @(posedge clock_in);
		cmp({wake_out, irq_out}, 2'h3);
		apb(1'b1, 12'h064, 32'h81);
		apb(1'b1, 12'h064, 32'h42);
		sleep_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		cmp(wake_out, 1'b0);
		ust_far_end_i.shift_in(8, got);
		cmp(got, 9'h181);
		repeat (3) @(posedge clock_in);
		cmp(wake_out, 1'b1);
		ust_far_end_i.shift_in(8, got);
		cmp(got, 9'h142);
		sleep_in <= 1'b0;
		apb(1'b1, 12'h02C, 32'h0);
		repeat (2) @(posedge clock_in);
		cmp({wake_out, irq_out}, 2'h2);
		apb(1'b1, 12'h030, 32'h0);
		rdc(12'h030, 32'h10);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
